/* core/dma_global_control_status.sv */
// Four-channel bus-master DMA with global control, status and debug registers
// Functional notes
// - Control bit 15 enables whole module
// - Suspend bit 12 holds off new transfers
// - Busy bit 11 shows module activity
// - Status bit 3 gives last access direction
// - Status bits 2-0 give last channel
// - Unimplemented control and status bits read zero
// - Four channels with incrementing address pointers
// - Fixed priority arbitration, channel 0 highest
// - Start by software force or interrupt
// - One-shot, auto-repeat and channel chaining
// - Selected interrupt aborts a channel transfer
// - Pattern match ends the block
// - Per-channel status events raised
// - Byte granular transfers, any alignment
// - One CRC generator attachable to any channel
// - Debug register holds last access address
//
// Added by the designer: the APB register port and the address map.
module dma_global_control_status
(
  input  wire logic              mclk_in,
  input  wire logic              rst_b_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [31:0]       paddr_in,
  input  wire logic [31:0]       pwdata_in,
  output logic [31:0]            prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  input  wire logic [31:0]       irq_src_in,
  output dma_pkg::mem_req_t      mem_out,
  input  wire dma_pkg::mem_rsp_t mem_in,
  output logic                   irq_out
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] pick(input logic [31:0] d, input logic [1:0] a);
    pick = d[{a, 3'b000} +: 8];
  endfunction

  function automatic logic [3:0] lane(input logic [1:0] a);
    lane = 4'h1 << a;
  endfunction

  function automatic logic [1:0] first_req(input logic [3:0] r);
    first_req = 2'h0;
    for (int k = 3; k >= 0; k--)
      if (r[k])
        first_req = 2'(k);
  endfunction

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d,
                                           input logic [15:0] p);
    logic [15:0] x;
    x = c ^ {d, 8'h00};
    for (int k = 0; k < 8; k++)
      x = x[15] ? ((x << 1) ^ p) : (x << 1);
    crc_step = x;
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic                   pready_r;
  logic                   pslverr_r;
  logic [31:0]            prdata_r;
  logic [31:0]            rdata_nxt;
  logic                   bad_nxt;
  logic                   on_r;
  logic                   susp_r;
  logic [31:0]            flag_r;
  logic [31:0]            flag_nxt;
  logic [31:0]            mask_r;
  logic [31:0]            crcc_r;
  logic [15:0]            crc_r;
  logic [7:0]             pat_r;
  logic                   dir_r;
  logic [2:0]             lch_r;
  logic [31:0]            laddr_r;
  logic                   irq_r;
  logic [31:0]            cctl_r [dma_pkg::NCH];
  logic [31:0]            src_r  [dma_pkg::NCH];
  logic [31:0]            dst_r  [dma_pkg::NCH];
  logic [15:0]            len_r  [dma_pkg::NCH];
  logic [15:0]            cnt_r  [dma_pkg::NCH];
  logic [3:0]             arm_r;
  dma_pkg::state_t        state_r;
  logic [1:0]             cur_r;
  logic [7:0]             byte_r;
  dma_pkg::mem_req_t      mem_r;
  logic [31:0]            ev;
  logic [3:0]             ready;
  logic [3:0]             abort_hit;
  logic [3:0]             done_ch;
  logic                   busy;
  logic                   grant;
  logic                   rd_ack;
  logic                   wr_fin;
  logic                   err_hit;
  logic                   last;
  logic [15:0]            ncnt;
  logic                   wr_acc;
  logic                   rd_acc;
  logic [7:0]             a8;
  logic                   ch_sel;
  logic [1:0]             ch_idx;
  logic [1:0]             ch_reg;

  assign a8     = paddr_in[7:0];
  assign ch_sel = (a8[7:6] == dma_pkg::CH_AREA);
  assign ch_idx = a8[5:4];
  assign ch_reg = a8[3:2];
  assign wr_acc = psel_in & penable_in & pready_r & pwrite_in & ~pslverr_r;
  assign rd_acc = psel_in & penable_in & ~pready_r & ~pwrite_in;

  // ****************************************
  // APB slave
  // ****************************************
  always_comb
  begin
    rdata_nxt = dma_pkg::RST_WORD;
    bad_nxt   = 1'b0;
    if (ch_sel)
      unique case (ch_reg)
        dma_pkg::C_CTL: rdata_nxt = cctl_r[ch_idx] & ~(32'h1 << dma_pkg::FORCE_B);
        dma_pkg::C_SRC: rdata_nxt = src_r[ch_idx];
        dma_pkg::C_DST: rdata_nxt = dst_r[ch_idx];
        dma_pkg::C_LEN: rdata_nxt = {cnt_r[ch_idx], len_r[ch_idx]};
      endcase
    else
      case (a8)
        dma_pkg::A_CTRL:
        begin
          rdata_nxt[dma_pkg::ON_B]   = on_r;
          rdata_nxt[dma_pkg::SUSP_B] = susp_r;
          rdata_nxt[dma_pkg::BUSY_B] = busy;
        end
        dma_pkg::A_STAT:  rdata_nxt[3:0] = {dir_r, lch_r};
        dma_pkg::A_LADDR: rdata_nxt = laddr_r;
        dma_pkg::A_FLAG:  rdata_nxt = flag_r;
        dma_pkg::A_MASK:  rdata_nxt = mask_r;
        dma_pkg::A_CRCC:  rdata_nxt = crcc_r;
        dma_pkg::A_CRCV:  rdata_nxt[15:0] = crc_r;
        dma_pkg::A_PATV:  rdata_nxt[7:0] = pat_r;
        default:          bad_nxt = 1'b1;
      endcase
  end

  // One wait state; the answer flops keep the bus outputs glitch free
  always_ff @(posedge mclk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= dma_pkg::RST_WORD;
    end
    else
    begin
      pready_r  <= psel_in & penable_in & ~pready_r;
      pslverr_r <= psel_in & penable_in & ~pready_r & bad_nxt;
      if (rd_acc)
        prdata_r <= rdata_nxt;
    end

  // ****************************************
  // Global control
  // ****************************************
  // module enable and suspend
  always_ff @(posedge mclk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      on_r   <= 1'b0;
      susp_r <= 1'b0;
      mask_r <= dma_pkg::RST_WORD;
      crcc_r <= dma_pkg::RST_WORD;
      pat_r  <= 8'h00;
    end
    else if (wr_acc && !ch_sel)
      case (a8)
        dma_pkg::A_CTRL:
        begin
          on_r   <= pwdata_in[dma_pkg::ON_B];
          susp_r <= pwdata_in[dma_pkg::SUSP_B];
        end
        dma_pkg::A_MASK: mask_r <= pwdata_in;
        dma_pkg::A_CRCC: crcc_r <= pwdata_in;
        dma_pkg::A_PATV: pat_r <= pwdata_in[7:0];
        default: ;
      endcase

  // busy while enabled or an access is in flight
  // busy drops only once the last access is done
  assign busy = on_r | (state_r != dma_pkg::S_IDLE);

  // ****************************************
  // Transfer engine
  // ****************************************
  always_comb
  begin
    for (int i = 0; i < dma_pkg::NCH; i++)
    begin
      ready[i]     = cctl_r[i][dma_pkg::CE_B] & arm_r[i];
      abort_hit[i] = cctl_r[i][dma_pkg::AIRQ_B] & arm_r[i]
                     & irq_src_in[cctl_r[i][dma_pkg::ASEL_L +: 5]];
    end
  end

  // no grant while disabled; none while suspended
  assign grant   = (state_r == dma_pkg::S_IDLE) & on_r & ~susp_r & (|ready);
  assign rd_ack  = (state_r == dma_pkg::S_RD) & mem_in.ack & ~mem_in.err;
  assign wr_fin  = (state_r == dma_pkg::S_WR) & mem_in.ack & ~mem_in.err;
  assign err_hit = (state_r != dma_pkg::S_IDLE) & mem_in.ack & mem_in.err;
  assign ncnt    = cnt_r[cur_r] + 16'h0001;
  assign last    = (ncnt == len_r[cur_r])
                   | (cctl_r[cur_r][dma_pkg::PAT_B] & (byte_r == pat_r));
  assign done_ch = (wr_fin & last & ~abort_hit[cur_r]) ? (4'h1 << cur_r) : 4'h0;

  // fixed priority grant; one byte per access, lane from address
  always_ff @(posedge mclk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      state_r <= dma_pkg::S_IDLE;
      cur_r   <= 2'h0;
      byte_r  <= 8'h00;
      mem_r   <= '0;
    end
    else
      unique case (state_r)
        dma_pkg::S_IDLE:
          if (grant)
          begin
            cur_r      <= first_req(ready);
            mem_r.req  <= 1'b1;
            mem_r.we   <= 1'b0;
            mem_r.addr <= src_r[first_req(ready)] + {16'h0, cnt_r[first_req(ready)]};
            mem_r.be   <= lane(2'(src_r[first_req(ready)] + {16'h0, cnt_r[first_req(ready)]}));
            state_r    <= dma_pkg::S_RD;
          end
        dma_pkg::S_RD:
          if (err_hit)
          begin
            mem_r.req <= 1'b0;
            state_r   <= dma_pkg::S_IDLE;
          end
          else if (rd_ack)
          begin
            byte_r      <= pick(mem_in.rdata, mem_r.addr[1:0]);
            mem_r.we    <= 1'b1;
            mem_r.addr  <= dst_r[cur_r] + {16'h0, cnt_r[cur_r]};
            mem_r.be    <= lane(2'(dst_r[cur_r] + {16'h0, cnt_r[cur_r]}));
            mem_r.wdata <= {4{pick(mem_in.rdata, mem_r.addr[1:0])}};
            state_r     <= dma_pkg::S_WR;
          end
        dma_pkg::S_WR:
          if (mem_in.ack)
          begin
            mem_r.req <= 1'b0;
            state_r   <= dma_pkg::S_IDLE;
          end
        default: state_r <= dma_pkg::S_IDLE;
      endcase

  // ****************************************
  // Channel registers
  // ****************************************
  // four channels, auto-incrementing offset into source and destination
  always_ff @(posedge mclk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      arm_r <= 4'h0;
      for (int i = 0; i < dma_pkg::NCH; i++)
      begin
        cctl_r[i] <= dma_pkg::RST_WORD;
        src_r[i]  <= dma_pkg::RST_WORD;
        dst_r[i]  <= dma_pkg::RST_WORD;
        len_r[i]  <= 16'h0000;
        cnt_r[i]  <= 16'h0000;
      end
    end
    else
      for (int i = 0; i < dma_pkg::NCH; i++)
      begin
        if (wr_acc && ch_sel && ch_idx == 2'(i))
          unique case (ch_reg)
            dma_pkg::C_CTL:
            begin
              cctl_r[i] <= pwdata_in;
              if (pwdata_in[dma_pkg::FORCE_B])
                arm_r[i] <= 1'b1;
            end
            dma_pkg::C_SRC: src_r[i] <= pwdata_in;
            dma_pkg::C_DST: dst_r[i] <= pwdata_in;
            dma_pkg::C_LEN:
            begin
              len_r[i] <= pwdata_in[15:0];
              cnt_r[i] <= 16'h0000;
            end
          endcase
        if (cctl_r[i][dma_pkg::SIRQ_B] && irq_src_in[cctl_r[i][dma_pkg::SSEL_L +: 5]])
          arm_r[i] <= 1'b1;
        // chained start after the lower channel's block
        if (i > 0 && cctl_r[i][dma_pkg::CHAIN_B] && done_ch[(i + 3) % 4])
          arm_r[i] <= 1'b1;
        if (wr_fin && cur_r == 2'(i))
        begin
          cnt_r[i] <= last ? 16'h0000 : ncnt;
          if (last && !cctl_r[i][dma_pkg::AUTO_B])
          begin
            arm_r[i]                <= 1'b0;
            cctl_r[i][dma_pkg::CE_B] <= 1'b0;
          end
        end
        if (abort_hit[i] || (err_hit && cur_r == 2'(i)))
        begin
          arm_r[i] <= 1'b0;
          cnt_r[i] <= 16'h0000;
        end
      end

  // ****************************************
  // Debug status
  // ****************************************
  // direction, channel and address move together
  always_ff @(posedge mclk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      dir_r   <= 1'b0;
      lch_r   <= 3'h0;
      laddr_r <= dma_pkg::RST_WORD;
    end
    else if (mem_r.req && mem_in.ack)
    begin
      dir_r   <= ~mem_r.we;
      lch_r   <= {1'b0, cur_r};
      laddr_r <= mem_r.addr;
    end

  // ****************************************
  // CRC
  // ****************************************
  // runs over source bytes of the attached channel
  always_ff @(posedge mclk_in or negedge rst_b_in)
    if (!rst_b_in)
      crc_r <= 16'h0000;
    else if (wr_acc && !ch_sel && a8 == dma_pkg::A_CRCV)
      crc_r <= pwdata_in[15:0];
    else if (rd_ack && crcc_r[dma_pkg::CRCEN_B] && crcc_r[2:0] == {1'b0, cur_r})
      crc_r <= crc_step(crc_r, pick(mem_in.rdata, mem_r.addr[1:0]),
                        crcc_r[dma_pkg::POLY_L +: 16]);

  // ****************************************
  // Events and interrupt
  // ****************************************
  // per-channel event byte
  always_comb
  begin
    ev = 32'h0;
    for (int i = 0; i < dma_pkg::NCH; i++)
    begin
      if (cur_r == 2'(i))
      begin
        ev[i * dma_pkg::EVW + dma_pkg::EV_DONE]  = done_ch[i];
        ev[i * dma_pkg::EVW + dma_pkg::EV_SHALF] = rd_ack & (ncnt == (len_r[i] >> 1));
        ev[i * dma_pkg::EVW + dma_pkg::EV_SEMPT] = rd_ack & (ncnt == len_r[i]);
        ev[i * dma_pkg::EVW + dma_pkg::EV_DHALF] = wr_fin & (ncnt == (len_r[i] >> 1));
        ev[i * dma_pkg::EVW + dma_pkg::EV_DFULL] = wr_fin & (ncnt == len_r[i]);
        ev[i * dma_pkg::EVW + dma_pkg::EV_AERR]  = err_hit;
      end
      ev[i * dma_pkg::EVW + dma_pkg::EV_ABORT] = abort_hit[i];
    end
  end

  // A set arriving with its write-one clear is kept
  assign flag_nxt = (flag_r & ~((wr_acc && !ch_sel && a8 == dma_pkg::A_FLAG) ? pwdata_in
                                                                             : 32'h0)) | ev;

  always_ff @(posedge mclk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      flag_r <= dma_pkg::RST_WORD;
      irq_r  <= 1'b0;
    end
    else
    begin
      flag_r <= flag_nxt;
      irq_r  <= |(flag_nxt & mask_r);
    end

  assign prdata_out  = prdata_r;
  assign pready_out  = pready_r;
  assign pslverr_out = pslverr_r;
  assign mem_out     = mem_r;
  assign irq_out     = irq_r;

  // ****************************************
  // Checks
  // ****************************************
  sequence seq_rd_done;
    state_r == dma_pkg::S_RD && rd_ack;
  endsequence

  sequence seq_idle_off;
    state_r == dma_pkg::S_IDLE && !on_r;
  endsequence

  a_disabled_idle: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    seq_idle_off |=> state_r == dma_pkg::S_IDLE && !mem_r.req)
    else $error("transfer started while disabled");
  a_suspend_hold: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    susp_r && state_r == dma_pkg::S_IDLE |=> state_r == dma_pkg::S_IDLE)
    else $error("transfer started while suspended");
  a_busy_clear: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    rd_acc && a8 == dma_pkg::A_CTRL && state_r == dma_pkg::S_IDLE && !on_r
    |=> !prdata_r[dma_pkg::BUSY_B])
    else $error("busy set while disabled and idle");
  a_busy_flight: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    rd_acc && a8 == dma_pkg::A_CTRL && (on_r || state_r != dma_pkg::S_IDLE)
    |=> prdata_r[dma_pkg::BUSY_B])
    else $error("busy clear while active");
  a_dir_read: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    seq_rd_done |=> dir_r && state_r == dma_pkg::S_WR && mem_r.we)
    else $error("read direction not recorded");
  a_debug_sync: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    mem_r.req && mem_in.ack |=> laddr_r == $past(mem_r.addr) && lch_r[1:0] == $past(cur_r))
    else $error("debug fields not updated together");
  a_status_zero: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    rd_acc && a8 == dma_pkg::A_STAT |=> prdata_r[31:4] == 28'h0 && pready_r)
    else $error("status reserved bits not zero");
  a_fixed_prio: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    grant && ready[0] |=> cur_r == 2'h0 && state_r == dma_pkg::S_RD)
    else $error("channel zero not preferred");
  a_one_shot: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    done_ch[0] && !cctl_r[0][dma_pkg::AUTO_B] && !abort_hit[0] |=> !arm_r[0] || $past(wr_acc))
    else $error("one-shot channel stayed armed");
  a_flag_set: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    ev[dma_pkg::EV_DONE] |=> flag_r[dma_pkg::EV_DONE] ##1 irq_r || !mask_r[0] || $past(wr_acc))
    else $error("done event lost");
endmodule

/* core/dma_pkg.sv */
// Shared constants and types of the DMA global control and status block
package dma_pkg;
  localparam int NCH = 4;
  localparam int EVW = 8;
  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_STAT  = 8'h04;
  localparam logic [7:0] A_LADDR = 8'h08;
  localparam logic [7:0] A_FLAG  = 8'h0c;
  localparam logic [7:0] A_MASK  = 8'h10;
  localparam logic [7:0] A_CRCC  = 8'h14;
  localparam logic [7:0] A_CRCV  = 8'h18;
  localparam logic [7:0] A_PATV  = 8'h1c;
  localparam logic [1:0] CH_AREA = 2'h1;
  localparam logic [1:0] C_CTL   = 2'h0;
  localparam logic [1:0] C_SRC   = 2'h1;
  localparam logic [1:0] C_DST   = 2'h2;
  localparam logic [1:0] C_LEN   = 2'h3;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int ON_B    = 15;
  localparam int SUSP_B  = 12;
  localparam int BUSY_B  = 11;
  localparam int DIR_B   = 3;
  localparam int CE_B    = 0;
  localparam int AUTO_B  = 1;
  localparam int CHAIN_B = 2;
  localparam int PAT_B   = 3;
  localparam int FORCE_B = 4;
  localparam int SIRQ_B  = 5;
  localparam int AIRQ_B  = 6;
  localparam int SSEL_L  = 8;
  localparam int ASEL_L  = 16;
  localparam int CRCEN_B = 7;
  localparam int POLY_L  = 16;
  localparam int EV_DONE = 0;
  localparam int EV_SHALF = 1;
  localparam int EV_SEMPT = 2;
  localparam int EV_DHALF = 3;
  localparam int EV_DFULL = 4;
  localparam int EV_ABORT = 5;
  localparam int EV_AERR = 6;
  localparam logic [31:0] RST_WORD = 32'h0;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {S_IDLE, S_RD, S_WR} state_t;
  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0]  be;
  } mem_req_t;
  typedef struct packed {
    logic [31:0] rdata;
    logic        ack;
    logic        err;
  } mem_rsp_t;
endpackage

/* verif/mem_model.sv */
// Memory and peripheral model on the far side of the DMA bus master
module mem_model
(
  input  wire logic              mclk_in,
  input  wire logic              rst_b_in,
  input  wire dma_pkg::mem_req_t req_in,
  input  wire logic [3:0]        wait_in,
  input  wire logic              err_in,
  output dma_pkg::mem_rsp_t      rsp_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  mem [0:255];
  logic [3:0]  cnt_r;
  logic [31:0] word;
  // ****************************************
  // Slave answer
  // ****************************************
  // Ack pulses once; read data goes stale between answers so a late sample shows
  always @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      cnt_r <= 4'h0;
      rsp_out <= '0;
    end
    else if (rsp_out.ack)
    begin
      rsp_out.ack <= 1'b0;
      rsp_out.err <= 1'b0;
      rsp_out.rdata <= ~rsp_out.rdata;
    end
    else if (req_in.req && cnt_r == wait_in)
    begin
      cnt_r <= 4'h0;
      word = {4{~mem[req_in.addr[7:0]]}};
      word[8*req_in.addr[1:0] +: 8] = mem[req_in.addr[7:0]];
      if (req_in.we && !err_in)
        mem[req_in.addr[7:0]] <= req_in.wdata[8*req_in.addr[1:0] +: 8];
      rsp_out.rdata <= word;
      rsp_out.ack <= 1'b1;
      rsp_out.err <= err_in;
    end
    else if (req_in.req)
      cnt_r <= cnt_r + 4'h1;
  end
endmodule

/* verif/dma_global_control_status_bench.sv */
// Self-checking bench of the DMA global control and status block
module dma_global_control_status_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic              mclk_in = 1'b0;
  logic              rst_b_in = 1'b0;
  logic              psel_in = 1'b0;
  logic              penable_in = 1'b0;
  logic              pwrite_in = 1'b0;
  logic [31:0]       paddr_in = 32'h0;
  logic [31:0]       pwdata_in = 32'h0;
  logic [31:0]       prdata_out;
  logic              pready_out;
  logic              pslverr_out;
  logic [31:0]       irq_src_in = 32'h0;
  dma_pkg::mem_req_t mem_out;
  dma_pkg::mem_rsp_t mem_in;
  logic              irq_out;
  logic [3:0]        wait_in = 4'h0;
  logic              err_in = 1'b0;
  int                num_errors = 0;
  int                n_compared = 0;
  int                cyc = 0;
  logic [31:0]       q;
  logic              e;
  always #50 mclk_in = ~mclk_in;
  dma_global_control_status u_dma_global_control_status (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .irq_src_in(irq_src_in), .mem_out(mem_out), .mem_in(mem_in),
    .irq_out(irq_out));
  mem_model u_mem_model (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .req_in(mem_out),
    .wait_in(wait_in), .err_in(err_in), .rsp_out(mem_in));
  // ****************************************
  // Shared tasks
  // ****************************************
  task results();
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge mclk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      num_errors++;
      results();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= {24'h0, a};
    pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    do @(posedge mclk_in); while (pready_out !== 1'b1);
    q = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task chan(input int ch, input logic [7:0] s, input logic [7:0] d, input logic [31:0] l,
            input logic [31:0] ctl);
    apb(1'b1, 8'h44 + 8'(ch * 16), {24'h0, s});
    apb(1'b1, 8'h48 + 8'(ch * 16), {24'h0, d});
    apb(1'b1, 8'h4c + 8'(ch * 16), l);
    apb(1'b1, 8'h40 + 8'(ch * 16), ctl);
  endtask
  task wflag(input logic [31:0] m);
    int i;
    for (i = 0; i < 100; i++)
    begin
      apb(1'b0, dma_pkg::A_FLAG, 32'h0);
      if ((q & m) === m)
        break;
    end
    chk(q & m, m);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_regs();
    rdchk(dma_pkg::A_CTRL, 32'h0);
    rdchk(dma_pkg::A_STAT, 32'h0);
    rdchk(dma_pkg::A_LADDR, 32'h0);
    apb(1'b1, dma_pkg::A_CTRL, 32'hffff_ffff);
    rdchk(dma_pkg::A_CTRL, 32'h0000_9800);
    apb(1'b1, dma_pkg::A_CTRL, 32'h0);
    rdchk(dma_pkg::A_CTRL, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    chk({31'h0, e}, 32'h1);
  endtask
  task t_copy();
    wait_in <= 4'h3;
    u_mem_model.mem[8'h10] = 8'h5a;
    u_mem_model.mem[8'h11] = 8'hc3;
    apb(1'b1, dma_pkg::A_CTRL, 32'h0000_8000);
    apb(1'b1, dma_pkg::A_MASK, 32'h0000_0001);
    chan(0, 8'h10, 8'h81, 32'h2, 32'h11);
    wflag(32'h1);
    chk({24'h0, u_mem_model.mem[8'h81]}, 32'h5a);
    chk({24'h0, u_mem_model.mem[8'h82]}, 32'hc3);
    rdchk(dma_pkg::A_STAT, 32'h0);
    rdchk(dma_pkg::A_LADDR, 32'h82);
    chk({31'h0, irq_out}, 32'h1);
    rdchk(dma_pkg::A_FLAG, 32'h1f);
    apb(1'b1, dma_pkg::A_FLAG, 32'h1f);
    rdchk(dma_pkg::A_FLAG, 32'h0);
    chk({31'h0, irq_out}, 32'h0);
    wait_in <= 4'h0;
  endtask
  // Suspended arming of two channels, then release
  task t_prio();
    int i;
    apb(1'b1, dma_pkg::A_CTRL, 32'h0000_9000);
    chan(3, 8'h20, 8'ha0, 32'h1, 32'h11);
    chan(2, 8'h30, 8'hb0, 32'h1, 32'h11);
    repeat (20) @(posedge mclk_in);
    chk({31'h0, mem_out.req}, 32'h0);
    rdchk(dma_pkg::A_FLAG, 32'h0);
    apb(1'b1, dma_pkg::A_CTRL, 32'h0000_8000);
    for (i = 0; i < 50 && mem_out.req !== 1'b1; i++)
      @(posedge mclk_in);
    chk(mem_out.addr, 32'h30);
    wflag(32'h0101_0000);
    rdchk(dma_pkg::A_STAT, 32'h3);
    rdchk(dma_pkg::A_LADDR, 32'ha0);
  endtask
  task t_irq();
    chan(1, 8'h10, 8'hc0, 32'h1, 32'h0521);
    repeat (20) @(posedge mclk_in);
    chk({31'h0, mem_out.req}, 32'h0);
    rdchk(dma_pkg::A_STAT, 32'h3);
    irq_src_in <= 32'h20;
    wflag(32'h100);
    irq_src_in <= 32'h0;
    rdchk(8'h50, 32'h0520);
    rdchk(dma_pkg::A_STAT, 32'h1);
  endtask
  task t_err();
    err_in <= 1'b1;
    chan(0, 8'h10, 8'hd0, 32'h1, 32'h11);
    wflag(32'h40);
    err_in <= 1'b0;
    apb(1'b1, dma_pkg::A_CTRL, 32'h0);
    repeat (3) @(posedge mclk_in);
    rdchk(dma_pkg::A_CTRL, 32'h0);
  endtask
  // Pattern end and CRC on channel 1, channel 2 chained behind it, then an abort
  task t_modes();
    u_mem_model.mem[8'h60] = 8'h01;
    u_mem_model.mem[8'h61] = 8'h77;
    u_mem_model.mem[8'h62] = 8'h3c;
    u_mem_model.mem[8'h71] = 8'h00;
    u_mem_model.mem[8'h7c] = 8'h00;
    apb(1'b1, dma_pkg::A_FLAG, 32'hffff_ffff);
    apb(1'b1, dma_pkg::A_PATV, 32'h0000_0001);
    apb(1'b1, dma_pkg::A_CRCC, 32'h1021_0081);
    apb(1'b1, dma_pkg::A_CRCV, 32'h0);
    chan(2, 8'h62, 8'h78, 32'h1, 32'h05);
    chan(1, 8'h60, 8'h70, 32'h4, 32'h19);
    wflag(32'h0001_0100);
    chk({24'h0, u_mem_model.mem[8'h70]}, 32'h01);
    chk({24'h0, u_mem_model.mem[8'h71]}, 32'h00);
    chk({24'h0, u_mem_model.mem[8'h78]}, 32'h3c);
    rdchk(8'h5c, 32'h4);
    rdchk(dma_pkg::A_CRCV, 32'h1021);
    // Armed while suspended, so only the abort can stop it
    apb(1'b1, dma_pkg::A_CTRL, 32'h0000_9000);
    chan(3, 8'h60, 8'h7c, 32'h1, 32'h0007_0051);
    irq_src_in <= 32'h80;
    wflag(32'h2000_0000);
    irq_src_in <= 32'h0;
    apb(1'b1, dma_pkg::A_CTRL, 32'h0000_8000);
    repeat (20) @(posedge mclk_in);
    chk({24'h0, u_mem_model.mem[8'h7c]}, 32'h00);
  endtask
  initial
  begin
    repeat (12) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    t_regs();
    t_copy();
    t_prio();
    t_irq();
    t_modes();
    t_err();
    results();
  end
endmodule
